// >>> rtl/local_pin_function_mux.sv
// multifunction pin selector with wishbone register slave
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
module local_pin_function_mux (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // wishbone slave
  input wire pin_mux_pkg::wb_req_t wb_req,
  input wire logic [3:0] wb_sel,
  output logic [31:0] wb_dat_o,
  output logic wb_ack,
  // local cycle state
  input wire pin_mux_pkg::local_cycle_t cycle,
  input wire logic interrupt_req_n,
  // pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  // interrupt
  output logic irq
);
  import pin_mux_pkg::*;

  logic [7:0] pin_function_select_hi;
  logic [7:0] pin_function_select_mid;
  logic [7:0] select_lo;
  logic [7:0] select_lo2;
  logic [7:0] out_port;
  logic [7:0] option5;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic [7:0] pin_in_q;
  logic local_status0_n;
  logic local_status1_n;
  logic local_mem_not_io;
  logic [7:0] next_pin_out;
  logic [7:0] next_pin_oe;

  wire [31:0] codes_all = {pin_function_select_hi, pin_function_select_mid, select_lo, select_lo2};
  wire access = wb_req.cyc & wb_req.stb & ~wb_ack;
  wire wr_en = access & wb_req.we & wb_sel[0];
  wire wr_hi = wr_en & (wb_req.adr == addr_select_hi);
  wire wr_mid = wr_en & (wb_req.adr == addr_select_mid);
  wire wr_lo = wr_en & (wb_req.adr == addr_select_lo);
  wire wr_lo2 = wr_en & (wb_req.adr == addr_select_lo2);
  wire wr_out = wr_en & (wb_req.adr == addr_out_port);
  wire wr_opt = wr_en & (wb_req.adr == addr_option5);
  wire wr_stat = wr_en & (wb_req.adr == addr_irq_status);
  wire wr_mask = wr_en & (wb_req.adr == addr_irq_mask);
  wire [7:0] rd_byte =
    (wb_req.adr == addr_select_hi) ? pin_function_select_hi :
    (wb_req.adr == addr_select_mid) ? pin_function_select_mid :
    (wb_req.adr == addr_select_lo) ? select_lo :
    (wb_req.adr == addr_select_lo2) ? select_lo2 :
    (wb_req.adr == addr_out_port) ? out_port :
    (wb_req.adr == addr_option5) ? option5 :
    (wb_req.adr == addr_irq_status) ? irq_status :
    (wb_req.adr == addr_irq_mask) ? irq_mask :
    (wb_req.adr == addr_pin_in) ? pin_in_q : 8'h00;

  // implicit-io flag: high only for implicit-io dma cycles
  wire dma_implicit_io_flag = cycle.dma_cycle & cycle.implicit_io; // RL1
  // ext-decode flag gated by the same chip-select timing
  wire ext_cycle_n = ~(cycle.ext_decode_cycle & cycle.chip_select_active); // RL2 RL3

  // pin codes that select the interrupt output
  logic [7:0] irq_pin_sel;
  logic [7:0] first_irq;

  // events: rising edge of each pin input
  wire [7:0] pin_rise = pin_in & ~pin_in_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_function_select_hi <= reset_select;
      pin_function_select_mid <= reset_select;
      select_lo <= reset_select;
      select_lo2 <= reset_select;
      out_port <= reset_byte;
      option5 <= reset_byte;
      irq_mask <= reset_byte;
    end else begin
      if (wr_hi) pin_function_select_hi <= wb_req.dat; // RL11
      if (wr_mid) pin_function_select_mid <= wb_req.dat; // RL11
      if (wr_lo) select_lo <= wb_req.dat;
      if (wr_lo2) select_lo2 <= wb_req.dat;
      if (wr_out) out_port <= wb_req.dat;
      if (wr_opt) option5 <= wb_req.dat;
      if (wr_mask) irq_mask <= wb_req.dat;
    end
  end

  // sticky status: set wins over write-one clear
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_status <= reset_byte;
    end else begin
      irq_status <= (irq_status & ~(wr_stat ? wb_req.dat : 8'h00)) | pin_rise;
    end
  end

  // local status copies latched at address latch strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      local_status0_n <= reset_status_n;
      local_status1_n <= reset_status_n;
      local_mem_not_io <= reset_mem_not_io;
      pin_in_q <= reset_byte;
    end else begin
      pin_in_q <= pin_in;
      if (cycle.addr_latch) begin
        local_status0_n <= cycle.status0_n; // RL4
        local_status1_n <= cycle.status1_n; // RL4
        local_mem_not_io <= cycle.mem_not_io; // RL4
      end
    end
  end

  // one interrupt pin at most: lowest selected pin wins
  always_comb begin
    irq_pin_sel = 8'h00;
    for (int i = 0; i < num_pins; i++) begin
      irq_pin_sel[i] = (codes_all[i*code_bits +: code_bits] == code_irq);
    end
    first_irq = irq_pin_sel & (~irq_pin_sel + 8'h01); // RL7
  end

  genvar p;
  generate
    for (p = 0; p < num_pins; p++) begin : g_pin
      wire [3:0] code = codes_all[p*code_bits +: code_bits];
      logic val;
      always_comb begin
        val = 1'b1;
        case (code)
          code_out_port: val = out_port[p]; // RL10
          code_option_a: val = (p == 6) ? option5[opt_bit_hi] : option5[opt_bit_lo]; // RL5
          code_irq: val = first_irq[p] ? interrupt_req_n : 1'b1; // RL6 RL7
          code_flag_d: val = (p == 2) ? ext_cycle_n : dma_implicit_io_flag; // RL1 RL2
          code_status: val = (p == 5) ? local_status0_n :
            (p == 6) ? local_status1_n : local_mem_not_io; // RL4
          default: val = 1'b1;
        endcase
      end
      assign next_pin_out[p] = val;
      assign next_pin_oe[p] = code[3]; // RL8
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_out <= reset_pins;
      pin_oe <= reset_byte;
      wb_ack <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      pin_out <= next_pin_out; // RL8
      pin_oe <= next_pin_oe;
      wb_ack <= access;
      // read data held until the next accepted request
      if (access) wb_dat_o <= {24'h000000, rd_byte}; // RL11
    end
  end

  assign irq = |(irq_status & irq_mask);
endmodule // local_pin_function_mux

// >>> pkg/pin_mux_pkg.sv
// constants and types for the multifunction pin selector
// Function
// (RL1) implicit-io flag high for implicit-io dma, low for host and addressed cycles
// (RL2) external-decode flag low while local cycle came from external decode
// (RL3) external-decode flag timed like the local chip selects
// (RL4) local status and mem/io copy bus lines, driven at address latch strobe
// (RL5) option register 5 bits 3 and 4 appear as static outputs when selected
// (RL6) software picks the interrupt line through option-select programming
// (RL7) at most one interrupt output active; unselected ones stay high
// (RL8) each pin carries the function its code field selects
// (RL9) software must not write reserved selection codes
// (RL10) general output pin drives output-port register bit of its index
// (RL11) selection registers read/write; function changes next clock after write
package pin_mux_pkg;
  localparam logic [7:0] addr_select_hi = 8'h1D;
  localparam logic [7:0] addr_select_mid = 8'h1E;
  localparam logic [7:0] addr_select_lo = 8'h1C;
  localparam logic [7:0] addr_select_lo2 = 8'h1B;
  localparam logic [7:0] addr_out_port = 8'h0F;
  localparam logic [7:0] addr_option5 = 8'h05;
  localparam logic [7:0] addr_irq_status = 8'h20;
  localparam logic [7:0] addr_irq_mask = 8'h21;
  localparam logic [7:0] addr_pin_in = 8'h22;
  localparam logic [7:0] reset_select = 8'h00;
  localparam logic [7:0] reset_byte = 8'h00;
  localparam logic [7:0] reset_pins = 8'hFF;
  localparam logic reset_status_n = 1'b1;
  localparam logic reset_mem_not_io = 1'b0;
  localparam int num_pins = 8;
  localparam int code_bits = 4;
  // output codes (bit 3 set = output)
  localparam logic [3:0] code_out_port = 4'h8;
  localparam logic [3:0] code_option_a = 4'hA;
  localparam logic [3:0] code_irq = 4'hC;
  localparam logic [3:0] code_flag_d = 4'hD;
  localparam logic [3:0] code_status = 4'hE;
  localparam int opt_bit_lo = 3;
  localparam int opt_bit_hi = 4;
  typedef struct packed {
    logic dma_cycle;
    logic implicit_io;
    logic ext_decode_cycle;
    logic chip_select_active;
    logic addr_latch;
    logic status0_n;
    logic status1_n;
    logic mem_not_io;
  } local_cycle_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [7:0] dat;
  } wb_req_t;
endpackage

// >>> tb/local_pin_function_mux_sva.sv
// port assertions for the pin selector
`timescale 1ns/1ps
module local_pin_function_mux_sva (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // watched ports
  input wire pin_mux_pkg::wb_req_t wb_req,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe
);
  import pin_mux_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_ack_pulse; wb_ack |=> !wb_ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_req; wb_req.cyc && wb_req.stb && !wb_ack |=> wb_ack; endproperty
  a_ack_req: assert property (p_ack_req) else $error("ack late");
  property p_ack_cyc; wb_ack |-> wb_req.cyc && wb_req.stb; endproperty
  a_ack_cyc: assert property (p_ack_cyc) else $error("ack without cycle");
  property p_ack_idle; !wb_req.stb |=> !wb_ack; endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("ack while idle");
  property p_dat_hi; wb_ack |-> wb_dat_o[31:8] == 24'h000000; endproperty
  a_dat_hi: assert property (p_dat_hi) else $error("upper data set");
  property p_dat_hold; !$stable(wb_dat_o) |-> wb_ack; endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("data moved");
  property p_oe_hold; !$stable(pin_oe) |-> $past(wb_ack); endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("enable moved");
  property p_rst; disable iff (1'b0) reset |=> pin_out == 8'hFF && pin_oe == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("pins not idle in reset");
endmodule // local_pin_function_mux_sva

// >>> tb/local_peripheral_model.sv
// local peripheral side of the multifunction pins
`timescale 1ns/1ps
module local_peripheral_model (
  // pins
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] drive,
  output logic [7:0] pin_in
);
  // device level while it drives, peripheral level otherwise
  assign pin_in = (pin_out & pin_oe) | (drive & ~pin_oe);
endmodule // local_peripheral_model

// >>> tb/local_pin_function_mux_tb.sv
// bench for the multifunction pin selector
`timescale 1ns/1ps
module local_pin_function_mux_tb;
  import pin_mux_pkg::*;
  logic clk = 0, reset = 1, irq_n = 1, irq, ack;
  wb_req_t rq = '0;
  local_cycle_t cy = '0;
  logic [7:0] drv = 8'h00, pin_in, pout, poe, rd;
  logic [3:0] sel = 4'h1;
  logic [31:0] dat;
  logic [7:0] sa [4] = '{addr_select_lo2, addr_select_lo, addr_select_mid, addr_select_hi};
  int fails = 0, tests_run = 0;
  always #2 clk = ~clk;
  local_pin_function_mux dut_u (.clk(clk), .reset(reset), .wb_req(rq), .wb_sel(sel),
    .wb_dat_o(dat), .wb_ack(ack), .cycle(cy), .interrupt_req_n(irq_n), .pin_in(pin_in),
    .pin_out(pout), .pin_oe(poe), .irq(irq));
  local_peripheral_model peer_u (.pin_out(pout), .pin_oe(poe), .drive(drv), .pin_in(pin_in));
  task automatic tally_and_finish;
    if (fails == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %0t %h %h", $time, s, e);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    rq <= '{1'b1, 1'b1, w, a, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = dat[7:0];
    if (n >= 50) begin
      fails++;
      tally_and_finish();
    end
    rq <= '0;
    @(posedge clk);
  endtask
  initial begin
    tick(5);
    reset <= 0;
    @(posedge clk);
    foreach (sa[i]) begin
      bus(1, sa[i], 8'h88);
      bus(0, sa[i], 8'h00);
      chk(rd, 8'h88);
    end
    bus(1, addr_out_port, 8'h55);
    tick(2);
    chk(pout, 8'h55);
    chk(poe, 8'hFF);
    sel <= 4'h0;
    bus(1, addr_out_port, 8'hAA);
    sel <= 4'h1;
    bus(0, addr_out_port, 8'h00);
    chk(rd, 8'h55);
    bus(1, 8'h40, 8'hFF);
    bus(0, 8'h40, 8'h00);
    chk(dat, 0);
    bus(1, addr_option5, 8'h10);
    bus(1, addr_select_hi, 8'hAA);
    tick(2);
    chk(pout[7:6], 2'b01);
    bus(1, addr_select_mid, 8'hC8);
    bus(1, addr_select_hi, 8'h8C);
    irq_n <= 0;
    tick(3);
    chk(pout[6:4], 3'b101);
    bus(1, addr_select_mid, 8'hE8);
    cy.status0_n <= 0;
    cy.addr_latch <= 1;
    tick(1);
    cy.addr_latch <= 0;
    cy.status0_n <= 1;
    tick(3);
    chk(pout[5], 0);
    bus(1, addr_select_lo, 8'h8D);
    bus(1, addr_select_hi, 8'h8D);
    cy <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    tick(3);
    chk({pout[6], pout[2]}, 2'b10);
    cy <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    tick(3);
    chk({pout[6], pout[2]}, 2'b01);
    cy <= '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    tick(3);
    chk({pout[6], pout[2]}, 2'b01);
    bus(1, addr_select_hi, 8'hEE);
    cy <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    tick(1);
    cy <= '0;
    tick(3);
    chk(pout[7:6], 2'b10);
    bus(1, addr_select_lo2, 8'h00);
    bus(1, addr_irq_status, 8'hFF);
    bus(1, addr_irq_mask, 8'h01);
    chk(irq, 0);
    drv <= 8'h01;
    tick(3);
    chk(irq, 1);
    bus(1, addr_irq_status, 8'h01);
    chk(irq, 0);
    bus(1, addr_irq_mask, 8'h00);
    drv <= 8'h00;
    tick(2);
    drv <= 8'h01;
    tick(3);
    chk(irq, 0);
    bus(0, addr_irq_status, 8'h00);
    chk(rd, 8'h01);
    drv <= 8'h00;
    tick(2);
    drv <= 8'h01;
    bus(1, addr_irq_status, 8'h01);
    bus(0, addr_irq_status, 8'h00);
    chk(rd[0], 1'b1);
    bus(0, addr_pin_in, 8'h00);
    chk(rd[1:0], 2'b01);
    tally_and_finish();
  end
endmodule // local_pin_function_mux_tb
bind local_pin_function_mux local_pin_function_mux_sva chk_u (.clk(clk), .reset(reset),
  .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack(wb_ack), .pin_out(pin_out), .pin_oe(pin_oe));
